// ==== rtl/pisu_pkg.sv ====
// Shared constants and types of the program isolation unit
package pisu_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned PISU_AW = 17;
  localparam int unsigned PISU_DW = 18;
  localparam int unsigned PISU_BLK_W = 5;
  localparam int unsigned PISU_SIZE_W = 6;
  localparam int unsigned PISU_BLK_SHIFT = 12;

  // ==========================================================
  // Instruction fields and codes
  localparam logic [3:0] PISU_F_ZERO = 4'h0;
  localparam logic [3:0] PISU_F_IO = 4'hF;
  // Address parts are decimal in the order code: 6020, 6021 and 1924
  localparam logic [12:0] PISU_N_ARM = 13'h1784;
  localparam logic [12:0] PISU_N_CANCEL = 13'h1785;
  localparam logic [12:0] PISU_N_RDST = 13'h0784;
  localparam logic [1:0] PISU_IO_IN = 2'h1;
  localparam logic [1:0] PISU_IO_OUT = 2'h3;
  localparam logic [17:0] PISU_NOP_WORD = 18'h1C000;

  // ==========================================================
  // Trap status layout and reset values
  localparam int unsigned PISU_ST_OOR = 17;
  localparam int unsigned PISU_ST_GEN_IN = 13;
  localparam int unsigned PISU_ST_PT_IN = 14;
  localparam int unsigned PISU_ST_GEN_OUT = 15;
  localparam int unsigned PISU_ST_PT_OUT = 16;
  localparam logic [17:0] PISU_TRAP_STATUS_RST = 18'h00000;

  // ==========================================================
  // Program levels and context save offsets
  localparam logic [2:0] PISU_LVL_BASE = 3'h4;
  localparam logic [2:0] PISU_LVL_TRAP = 3'h3;
  localparam logic [16:0] PISU_CTX_S_OFS = 17'h00006;
  localparam logic [16:0] PISU_CTX_B_OFS = 17'h00007;

endpackage

// ==== rtl/pisu_path_if.sv ====
// Internal carrier between the isolation top and its helpers
`timescale 1ns/100ps
interface pisu_path_if;
  logic [16:0] cpu_addr;
  logic cpu_auto;
  logic slave;
  logic [4:0] base_blk;
  logic [5:0] store_blks;
  logic [16:0] phys_addr;
  logic oor;
  logic [17:0] ins_word;
  logic is_io;
  logic is_arm;
  logic is_cancel;
  logic is_rdst;
  logic is_f0;
  logic [17:0] io_status;

  modport reloc (
    input cpu_addr, cpu_auto, slave, base_blk, store_blks,
    output phys_addr, oor
  );
  modport dec (
    input ins_word,
    output is_io, is_arm, is_cancel, is_rdst, is_f0, io_status
  );
  modport top (
    output cpu_addr, cpu_auto, slave, base_blk, store_blks, ins_word,
    input phys_addr, oor, is_io, is_arm, is_cancel, is_rdst, is_f0, io_status
  );
endinterface

// ==== rtl/pisu_reloc.sv ====
// Address relocation and installed-store range check
`timescale 1ns/100ps
module pisu_reloc (
  // Path signals
  pisu_path_if.reloc p
);
  import pisu_pkg::*;

  logic [17:0] sum;
  logic [17:0] eff;
  logic relocate;

  // ==========================================================
  // Relocation: base sits on 4096-word boundaries, so a shift does it
  always_comb begin
    relocate = p.slave && !p.cpu_auto;
    sum = {1'b0, p.cpu_addr} + {1'b0, p.base_blk, 12'h000};
    eff = relocate ? sum : {1'b0, p.cpu_addr};
  end

  // Range check covers the carry, so wrap past the top also traps
  assign p.oor = relocate && (eff[17:12] >= p.store_blks);
  assign p.phys_addr = eff[16:0];

endmodule

// ==== rtl/pisu_decode.sv ====
// Instruction classification and input-output trap word
`timescale 1ns/100ps
module pisu_decode (
  // Path signals
  pisu_path_if.dec p
);
  import pisu_pkg::*;

  logic [3:0] f;
  logic [12:0] n;
  logic f15;

  // Builds the status word captured when an input-output order traps
  function automatic logic [17:0] io_word(input logic [12:0] nn);
    logic in_c;
    logic out_c;
    logic pt;
    logic [17:0] w;
    in_c = (nn[12:11] == PISU_IO_IN);
    out_c = (nn[12:11] == PISU_IO_OUT);
    pt = (nn[10:4] == 7'h00);
    w = 18'h00000;
    w[3:0] = nn[3:0];
    w[10:4] = pt ? 7'h00 : nn[10:4];
    w[PISU_ST_GEN_IN] = in_c && !pt;
    w[PISU_ST_PT_IN] = in_c && pt;
    w[PISU_ST_GEN_OUT] = out_c && !pt;
    w[PISU_ST_PT_OUT] = out_c && pt;
    return w;
  endfunction

  // ==========================================================
  // Field split: modifier bit on top, function, then address part
  assign f = p.ins_word[16:13];
  assign n = p.ins_word[12:0];
  assign f15 = (f == PISU_F_IO);

  assign p.is_f0 = (f == PISU_F_ZERO);
  assign p.is_arm = f15 && (n == PISU_N_ARM);
  assign p.is_cancel = f15 && (n == PISU_N_CANCEL);
  assign p.is_rdst = f15 && (n == PISU_N_RDST);
  assign p.is_io = f15 && ((n[12:11] == PISU_IO_IN) || (n[12:11] == PISU_IO_OUT));
  assign p.io_status = io_word(n);

endmodule

// ==== rtl/pisu_top.sv ====
// Program isolation unit: mode control, traps and status
`timescale 1ns/100ps

// Overview of operation
// - One stored bit selects normal or slave; normal leaves processor untouched.
// - Slave mode adds base to processor addresses, never to autonomous ones.
// - Base is a 4096-word multiple; slave location zero is the base.
// - Slave reference beyond installed store returns to normal mode.
// - Slave input-output orders are withheld from peripherals and exit slave.
// - Any interrupt signal in slave mode returns to normal mode.
// - Range and input-output traps raise level 3 and record status.
// - Range trap status holds offending address low, top bit set.
// - Input-output trap copies address bits 1-4, and 5-11 unless paper tape.
// - Trap interrupt follows its instruction, but after function zero only in slave mode before another.
// - Fetch from out of range returns the do-nothing shift word.
// - Operand read out of range returns the same shift word.
// - Store to out of range writes nothing; registers update normally.
// - Block transfer in slave mode acts as the no-operation.
// - In slave mode interrupt after function zero only before another.
// - Arm order arms entry at next level 4 and clears status.
// - Cancel order exits slave with level 3 interrupt, or disarms on level 3.
// - Status read order copies status to accumulator, status unchanged.
// - Slave only while level 4 runs; levels 1-3 force normal.
// - Level 4 start enters slave only if armed beforehand.
// - Entry loads sequence and modifier from base+6/+7; exit saves them.
module pisu_top (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Configuration
  input wire logic [pisu_pkg::PISU_BLK_W-1:0] base_blk,
  input wire logic [pisu_pkg::PISU_SIZE_W-1:0] store_blks,
  // Store cycle from processor or autonomous channel
  input wire logic st_req,
  input wire logic st_auto,
  input wire logic st_write,
  input wire logic [pisu_pkg::PISU_AW-1:0] st_addr,
  input wire logic [pisu_pkg::PISU_DW-1:0] mem_rdata,
  output logic [pisu_pkg::PISU_AW-1:0] mem_addr,
  output logic mem_we,
  output logic [pisu_pkg::PISU_DW-1:0] cpu_rdata,
  // Instruction execution
  input wire logic ins_valid,
  input wire logic [pisu_pkg::PISU_DW-1:0] ins_word,
  input wire logic ins_blk,
  input wire logic next_f0,
  output logic io_withhold,
  output logic blk_nop,
  output logic acc_load,
  output logic [pisu_pkg::PISU_DW-1:0] acc_data,
  // Program levels and interrupts
  input wire logic [2:0] level,
  input wire logic ext_irq,
  input wire logic irq_ack,
  output logic irq_l3,
  output logic irq_allow,
  output logic slave_mode,
  output logic ctx_load,
  output logic ctx_save,
  output logic [pisu_pkg::PISU_AW-1:0] ctx_s_addr,
  output logic [pisu_pkg::PISU_AW-1:0] ctx_b_addr
);
  import pisu_pkg::*;

  pisu_path_if pth ();

  logic slave_q;
  logic armed_q;
  logic [17:0] trap_status_q;
  logic trap_irq_q;
  logic prev_f0_q;
  logic [2:0] level_q;
  logic acc_load_q;
  logic [17:0] acc_data_q;
  logic ctx_load_q;
  logic ctx_save_q;
  logic [16:0] ctx_s_q;
  logic [16:0] ctx_b_q;
  logic cpu_cyc;
  logic oor_ev;
  logic io_ev;
  logic cancel_ev;
  logic exit_ev;
  logic entry_ev;
  logic arm_ev;
  logic disarm_ev;
  logic rdst_ev;

  // ==========================================================
  // Helpers
  assign pth.cpu_addr = st_addr;
  assign pth.cpu_auto = st_auto;
  assign pth.slave = slave_q;
  assign pth.base_blk = base_blk;
  assign pth.store_blks = store_blks;
  assign pth.ins_word = ins_word;

  pisu_reloc u_reloc (
    .p (pth.reloc)
  );

  pisu_decode u_decode (
    .p (pth.dec)
  );

  // ==========================================================
  // Events of this cycle
  assign cpu_cyc = st_req && !st_auto;
  assign oor_ev = cpu_cyc && pth.oor;
  // Own control orders other than cancel count as input-output in slave mode
  assign io_ev = ins_valid && slave_q
    && (pth.is_io || pth.is_arm || pth.is_rdst);
  assign cancel_ev = ins_valid && slave_q && pth.is_cancel;
  assign exit_ev = slave_q && (oor_ev || io_ev || cancel_ev || ext_irq
    || (level != PISU_LVL_BASE));
  assign entry_ev = !slave_q && armed_q && (level == PISU_LVL_BASE)
    && (level_q != PISU_LVL_BASE);
  assign arm_ev = ins_valid && !slave_q && pth.is_arm;
  assign disarm_ev = ins_valid && !slave_q && pth.is_cancel
    && (level == PISU_LVL_TRAP);
  assign rdst_ev = ins_valid && !slave_q && pth.is_rdst;

  // ==========================================================
  // Store path: relocated address, withheld write, substituted read data
  assign mem_addr = pth.phys_addr;
  assign mem_we = st_req && st_write && !pth.oor;
  assign cpu_rdata = (cpu_cyc && pth.oor) ? PISU_NOP_WORD : mem_rdata;

  // Instruction side effects, combinational so the core sees them in the cycle
  assign io_withhold = io_ev;
  assign blk_nop = ins_valid && slave_q && ins_blk;

  // Interrupt window: only slave mode may break a function-zero pair
  assign irq_allow = !prev_f0_q || (slave_q && next_f0);
  assign irq_l3 = trap_irq_q && irq_allow;

  assign slave_mode = slave_q;
  assign acc_load = acc_load_q;
  assign acc_data = acc_data_q;
  assign ctx_load = ctx_load_q;
  assign ctx_save = ctx_save_q;
  assign ctx_s_addr = ctx_s_q;
  assign ctx_b_addr = ctx_b_q;

  // ==========================================================
  // Mode bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slave_q <= 1'b0;
    end else if (exit_ev) begin
      slave_q <= 1'b0;
    end else if (entry_ev) begin
      slave_q <= 1'b1;
    end
  end

  // Arming is consumed by the entry it causes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_q <= 1'b0;
    end else if (arm_ev) begin
      armed_q <= 1'b1;
    end else if (disarm_ev || entry_ev) begin
      armed_q <= 1'b0;
    end
  end

  // Level history for the level 4 start edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      level_q <= PISU_LVL_BASE;
    end else begin
      level_q <= level;
    end
  end

  // ==========================================================
  // Trap status; a range trap outranks an order in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trap_status_q <= PISU_TRAP_STATUS_RST;
    end else if (oor_ev) begin
      trap_status_q <= {1'b1, st_addr};
    end else if (io_ev) begin
      trap_status_q <= pth.io_status;
    end else if (arm_ev) begin
      trap_status_q <= PISU_TRAP_STATUS_RST;
    end
  end

  // Pending level 3 request; a new trap wins over an acknowledge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trap_irq_q <= 1'b0;
    end else if (oor_ev || io_ev || cancel_ev) begin
      trap_irq_q <= 1'b1;
    end else if (irq_ack) begin
      trap_irq_q <= 1'b0;
    end
  end

  // Remembers whether the last executed order was function zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_f0_q <= 1'b0;
    end else if (ins_valid) begin
      prev_f0_q <= pth.is_f0;
    end
  end

  // ==========================================================
  // Status read into the accumulator, status left as it is
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_load_q <= 1'b0;
      acc_data_q <= PISU_TRAP_STATUS_RST;
    end else begin
      acc_load_q <= rdst_ev;
      if (rdst_ev) begin
        acc_data_q <= trap_status_q;
      end
    end
  end

  // Context move requests; addresses follow the base every cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctx_load_q <= 1'b0;
      ctx_save_q <= 1'b0;
      ctx_s_q <= PISU_CTX_S_OFS;
      ctx_b_q <= PISU_CTX_B_OFS;
    end else begin
      ctx_load_q <= entry_ev;
      ctx_save_q <= exit_ev;
      ctx_s_q <= {base_blk, 12'h000} + PISU_CTX_S_OFS;
      ctx_b_q <= {base_blk, 12'h000} + PISU_CTX_B_OFS;
    end
  end

  // ==========================================================
  // Checks
  sequence s_left_slave;
    !slave_q && ctx_save_q;
  endsequence

  sequence s_range_recorded;
    trap_status_q[PISU_ST_OOR] && trap_irq_q;
  endsequence

  property p_level_gate;
    @(posedge clk) disable iff (!arst_n)
      (slave_q && level != PISU_LVL_BASE) |=> s_left_slave;
  endproperty
  a_level_gate: assert property (p_level_gate) else $error("slave kept off level 4");

  property p_auto_plain;
    @(posedge clk) disable iff (!arst_n)
      (st_req && st_auto) |-> (mem_addr == st_addr);
  endproperty
  a_auto_plain: assert property (p_auto_plain) else $error("autonomous address moved");

  property p_reloc;
    @(posedge clk) disable iff (!arst_n)
      (cpu_cyc && slave_q && !pth.oor)
        |-> (mem_addr == st_addr + {base_blk, 12'h000});
  endproperty
  a_reloc: assert property (p_reloc) else $error("slave address not relocated");

  property p_range_trap;
    @(posedge clk) disable iff (!arst_n)
      oor_ev |=> s_left_slave ##0 s_range_recorded
        ##0 (trap_status_q[16:0] == $past(st_addr));
  endproperty
  a_range_trap: assert property (p_range_trap) else $error("range trap not taken");

  property p_io_trap;
    @(posedge clk) disable iff (!arst_n)
      (io_ev && !oor_ev) |-> io_withhold
        ##1 (!slave_q && !trap_status_q[PISU_ST_OOR] && trap_irq_q);
  endproperty
  a_io_trap: assert property (p_io_trap) else $error("io order not trapped");

  property p_ext_exit;
    @(posedge clk) disable iff (!arst_n)
      (slave_q && ext_irq) |=> !slave_q;
  endproperty
  a_ext_exit: assert property (p_ext_exit) else $error("interrupt left slave on");

  property p_sub_word;
    @(posedge clk) disable iff (!arst_n)
      (cpu_cyc && pth.oor) |-> (cpu_rdata == PISU_NOP_WORD) && !mem_we;
  endproperty
  a_sub_word: assert property (p_sub_word) else $error("out of range access leaked");

  property p_arm;
    @(posedge clk) disable iff (!arst_n)
      arm_ev |=> armed_q && (trap_status_q == PISU_TRAP_STATUS_RST);
  endproperty
  a_arm: assert property (p_arm) else $error("arm order not applied");

  property p_rdst;
    @(posedge clk) disable iff (!arst_n)
      rdst_ev |=> acc_load && (acc_data == $past(trap_status_q))
        && $stable(trap_status_q);
  endproperty
  a_rdst: assert property (p_rdst) else $error("status read wrong");

  property p_entry;
    @(posedge clk) disable iff (!arst_n)
      entry_ev |=> slave_q && ctx_load && !armed_q;
  endproperty
  a_entry: assert property (p_entry) else $error("slave entry missed");

  property p_f0_hold;
    @(posedge clk) disable iff (!arst_n)
      (prev_f0_q && !(slave_q && next_f0)) |-> !irq_l3;
  endproperty
  a_f0_hold: assert property (p_f0_hold) else $error("interrupt after function zero");

endmodule

// ==== bench/pisu_core_model.sv ====
// Store model standing behind the isolation unit on the core's store bus
`timescale 1ns/100ps
module pisu_core_model (
  // Clock
  input wire logic clk,
  // Store bus from the unit
  input wire logic [16:0] mem_addr,
  input wire logic mem_we,
  output logic [17:0] mem_rdata,
  // Observation
  output logic [15:0] wr_count
);
  // ==========================================================
  // Read data
  // Pattern depends on the address so a wrong relocation never reads back the expected word
  always @* begin
    mem_rdata = {1'b0, mem_addr} ^ 18'h15555;
  end

  // ==========================================================
  // Write counting
  // Writes are only counted; a dropped write shows as an unchanged count
  initial wr_count = 16'h0000;
  always @(posedge clk) begin
    if (mem_we === 1'b1) begin
      wr_count <= wr_count + 16'h0001;
    end
  end
endmodule

// ==== bench/test_pisu_top.sv ====
// Self-checking bench of the program isolation unit
`timescale 1ns/100ps
module test_pisu_top;
  import pisu_pkg::*;
  logic clk, arst_n, st_req, st_auto, st_write, ins_valid, ins_blk, next_f0;
  logic ext_irq, irq_ack, mem_we, io_withhold, blk_nop, acc_load, irq_l3, irq_allow;
  logic slave_mode, ctx_load, ctx_save, w0, b0;
  logic [4:0] base_blk;
  logic [5:0] store_blks;
  logic [16:0] st_addr, mem_addr, ctx_s_addr, ctx_b_addr;
  logic [17:0] mem_rdata, cpu_rdata, ins_word, acc_data;
  logic [2:0] level;
  logic [15:0] wr_count;
  int bad_count, num_checks, cyc;
  // Base block 2 and four installed blocks: slave space ends at offset 17'h02000
  localparam logic [17:0] ARM = {1'b0, PISU_F_IO, PISU_N_ARM};
  localparam logic [17:0] CANCEL = {1'b0, PISU_F_IO, PISU_N_CANCEL};
  localparam logic [17:0] RDST = {1'b0, PISU_F_IO, PISU_N_RDST};

  // ==========================================================
  // Design and store model
  pisu_top dut (.clk(clk), .arst_n(arst_n), .base_blk(base_blk), .store_blks(store_blks),
    .st_req(st_req), .st_auto(st_auto), .st_write(st_write), .st_addr(st_addr),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_we(mem_we), .cpu_rdata(cpu_rdata),
    .ins_valid(ins_valid), .ins_word(ins_word), .ins_blk(ins_blk), .next_f0(next_f0),
    .io_withhold(io_withhold), .blk_nop(blk_nop), .acc_load(acc_load), .acc_data(acc_data),
    .level(level), .ext_irq(ext_irq), .irq_ack(irq_ack), .irq_l3(irq_l3),
    .irq_allow(irq_allow), .slave_mode(slave_mode), .ctx_load(ctx_load),
    .ctx_save(ctx_save), .ctx_s_addr(ctx_s_addr), .ctx_b_addr(ctx_b_addr));
  pisu_core_model core (.clk(clk), .mem_addr(mem_addr), .mem_we(mem_we),
    .mem_rdata(mem_rdata), .wr_count(wr_count));

  // ==========================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Whole run needs well under a thousand cycles
  initial cyc = 0;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic go();
    @(posedge clk);
    #1;
  endtask
  // One instruction; an idle edge first so valid is never redriven in one step
  task automatic exec(input logic [17:0] w, input logic blk);
    go();
    ins_word = w;
    ins_blk = blk;
    ins_valid = 1'b1;
    #1;
    w0 = io_withhold;
    b0 = blk_nop;
    go();
    ins_valid = 1'b0;
    ins_blk = 1'b0;
  endtask
  task automatic enter(input logic armed);
    level = 3'h3;
    if (armed) begin
      exec(ARM, 1'b0);
    end
    go();
    level = 3'h4;
    go();
    chk("slave_mode", slave_mode, armed);
    chk("ctx_load", ctx_load, armed);
  endtask
  task automatic store(input logic [16:0] a, input logic au, input logic wr);
    go();
    st_req = 1'b1;
    st_addr = a;
    st_auto = au;
    st_write = wr;
    #1;
  endtask
  task automatic store_end();
    go();
    st_req = 1'b0;
    st_write = 1'b0;
    st_auto = 1'b0;
  endtask
  task automatic read_status(input logic [17:0] exp);
    exec(RDST, 1'b0);
    chk("acc_load", acc_load, 1'b1);
    chk("acc_data", acc_data, exp);
  endtask
  task automatic take_irq();
    chk("irq_l3", irq_l3, 1'b1);
    irq_ack = 1'b1;
    go();
    irq_ack = 1'b0;
    chk("irq_l3 cleared", irq_l3, 1'b0);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_normal_and_reloc();
    store(17'h00123, 1'b0, 1'b0);
    chk("normal addr", mem_addr, 17'h00123);
    chk("normal data", cpu_rdata, 18'h15476);
    store_end();
    enter(1'b0);
    enter(1'b1);
    chk("ctx_s_addr", ctx_s_addr, 17'h02006);
    chk("ctx_b_addr", ctx_b_addr, 17'h02007);
    store(17'h00010, 1'b0, 1'b1);
    chk("reloc addr", mem_addr, 17'h02010);
    chk("reloc we", mem_we, 1'b1);
    store_end();
    store(17'h00010, 1'b1, 1'b0);
    chk("auto addr", mem_addr, 17'h00010);
    store_end();
  endtask
  task automatic t_range_trap();
    logic [15:0] n0;
    n0 = wr_count;
    store(17'h02000, 1'b0, 1'b1);
    chk("oor we", mem_we, 1'b0);
    chk("oor data", cpu_rdata, PISU_NOP_WORD);
    store_end();
    chk("oor exit", slave_mode, 1'b0);
    chk("oor save", ctx_save, 1'b1);
    chk("no write", wr_count, n0);
    take_irq();
    read_status(18'h22000);
    read_status(18'h22000);
  endtask
  task automatic t_io(input logic [12:0] n, input logic [17:0] exp);
    level = 3'h3;
    exec(ARM, 1'b0);
    read_status(18'h00000);
    go();
    level = 3'h4;
    go();
    chk("io entry", slave_mode, 1'b1);
    exec({1'b0, PISU_F_IO, n}, 1'b0);
    chk("io withhold", w0, 1'b1);
    chk("io exit", slave_mode, 1'b0);
    take_irq();
    read_status(exp);
  endtask
  task automatic t_block_and_exits();
    exec(18'h08005, 1'b1);
    chk("blk normal", b0, 1'b0);
    enter(1'b1);
    exec(18'h08005, 1'b1);
    chk("blk slave", b0, 1'b1);
    next_f0 = 1'b1;
    exec(18'h00005, 1'b0);
    chk("allow f0 f0", irq_allow, 1'b1);
    next_f0 = 1'b0;
    exec(18'h00005, 1'b0);
    chk("allow f0", irq_allow, 1'b0);
    exec(CANCEL, 1'b0);
    chk("cancel exit", slave_mode, 1'b0);
    chk("cancel save", ctx_save, 1'b1);
    take_irq();
    level = 3'h3;
    exec(ARM, 1'b0);
    exec(CANCEL, 1'b0);
    go();
    level = 3'h4;
    go();
    chk("disarmed", slave_mode, 1'b0);
    enter(1'b1);
    ext_irq = 1'b1;
    go();
    ext_irq = 1'b0;
    go();
    chk("irq exit", slave_mode, 1'b0);
    enter(1'b1);
    level = 3'h2;
    go();
    go();
    chk("level exit", slave_mode, 1'b0);
  endtask

  // ==========================================================
  // Closing report
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    bad_count = 0;
    num_checks = 0;
    arst_n = 1'b0;
    base_blk = 5'h02;
    store_blks = 6'h04;
    {st_req, st_auto, st_write, ins_valid, ins_blk, next_f0, ext_irq, irq_ack} = 8'h00;
    st_addr = 17'h00000;
    ins_word = 18'h00000;
    level = 3'h4;
    repeat (2) @(posedge clk);
    #1;
    chk("rst slave", slave_mode, 1'b0);
    chk("rst acc", acc_data, PISU_TRAP_STATUS_RST);
    chk("rst ctx", ctx_s_addr, 17'h00006);
    arst_n = 1'b1;
    go();
    read_status(18'h00000);
    t_normal_and_reloc();
    t_range_trap();
    t_io(13'h085A, 18'h0205A);
    t_io(13'h0803, 18'h04003);
    t_io(13'h185A, 18'h0805A);
    t_io(13'h1803, 18'h10003);
    t_block_and_exits();
    report_and_stop();
  end
endmodule
